// ==== rtl/bsrom_consts.vh ====
// constants for the bootstrap store read path
`ifndef BSROM_CONSTS_VH
`define BSROM_CONSTS_VH
`define BSROM_ADDR_W 14
`define BSROM_WORD_W 26
`define BSROM_HALF_W 13
`define BSROM_RANGE_HI 10'h003
`define BSROM_GRP_BIT 3
`define BSROM_STROBE_NS 1000
`define BSROM_CYCLE_NS 4000
`define BSROM_CLK_NS 100
`define BSROM_STROBE_CYC (`BSROM_STROBE_NS / `BSROM_CLK_NS)
`define BSROM_CYCLE_CYC (`BSROM_CYCLE_NS / `BSROM_CLK_NS)
`endif

// ==== rtl/bsrom_half.v ====
// one half of the fixed store: word line readout from the stored cells
`timescale 1ns/100ps
module bsrom_half #(
    parameter WORDS = 32,
    parameter HALF_W = 13
) (
    input wire alt_half, // strap: read spare copy
    input wire grp, // group driver select
    input wire [2:0] line, // word line index
    input wire [WORDS*HALF_W-1:0] cells, // stored words, word 0 lowest
    output reg [HALF_W-1:0] word // 12 data bits plus parity
);
    reg [4:0] idx;
    always @* begin
        idx = {alt_half, grp, line};
        word = cells[idx*HALF_W +: HALF_W];
    end
endmodule

// ==== rtl/bsrom_path.v ====
// bootstrap store read path: range decode, drivers, gate into data register
// Contract
// - sixteen usable words, twenty-six bits each
// - thirty-two stored words, strap selects copy
// - two halves: bits 0-11, 13-24 with parities in 12 and 25
// - paper tape and magnetic tape loaders
// - octal 60 through 77 are bootstrap
// - range asserts group, line, enable, gate
// - enable from bits 4-13 inhibits core
// - gate opens data register to store
// - bit 3 picks word group driver
// - bits 0-2 one-hot word line driver
// - selected word loaded into data register
// - data register loads one microsecond in
// - whole cycle lasts four microseconds
`timescale 1ns/100ps
`include "bsrom_consts.vh"
module bsrom_path #(
    parameter STROBE_CYC = `BSROM_STROBE_CYC,
    parameter CYCLE_CYC = `BSROM_CYCLE_CYC
) (
    input wire clk, // 10 MHz clock
    input wire arst_n, // async reset, active low
    input wire [13:0] mar, // memory address register
    input wire start, // memory cycle start pulse
    input wire alt_half, // strap pin: read spare copy
    input wire [25:0] core_word, // core sense outputs, both halves
    output reg [1:0] grp_drv, // word group drivers
    output reg [7:0] line_drv, // word line drivers, one-hot
    output reg boot_en, // inhibits main memory control
    output reg boot_gate, // data register takes bootstrap word
    output reg [25:0] mdr, // memory data register
    output reg read_strobe, // one-cycle load pulse
    output reg busy // memory cycle in progress
);
    localparam ST_IDLE = 3'b001;
    localparam ST_READ = 3'b010;
    localparam ST_RESTORE = 3'b100;

    // used words, parity in bit 12; paper tape loader 0-7, magnetic tape 8-15
    localparam [12:0] LO_W0 = 13'h0001;
    localparam [12:0] LO_W1 = 13'h1060;
    localparam [12:0] LO_W2 = 13'h0002;
    localparam [12:0] LO_W3 = 13'h0070;
    localparam [12:0] LO_W4 = 13'h1003;
    localparam [12:0] LO_W5 = 13'h0061;
    localparam [12:0] LO_W6 = 13'h0004;
    localparam [12:0] LO_W7 = 13'h1060;
    localparam [12:0] LO_W8 = 13'h1011;
    localparam [12:0] LO_W9 = 13'h0068;
    localparam [12:0] LO_W10 = 13'h1012;
    localparam [12:0] LO_W11 = 13'h1078;
    localparam [12:0] LO_W12 = 13'h0013;
    localparam [12:0] LO_W13 = 13'h1069;
    localparam [12:0] LO_W14 = 13'h1014;
    localparam [12:0] LO_W15 = 13'h0068;

    // upper half of the same sixteen words
    localparam [12:0] HI_W0 = 13'h0040;
    localparam [12:0] HI_W1 = 13'h0100;
    localparam [12:0] HI_W2 = 13'h13C0;
    localparam [12:0] HI_W3 = 13'h01C0;
    localparam [12:0] HI_W4 = 13'h1440;
    localparam [12:0] HI_W5 = 13'h1500;
    localparam [12:0] HI_W6 = 13'h1780;
    localparam [12:0] HI_W7 = 13'h1740;
    localparam [12:0] HI_W8 = 13'h1041;
    localparam [12:0] HI_W9 = 13'h1101;
    localparam [12:0] HI_W10 = 13'h03C1;
    localparam [12:0] HI_W11 = 13'h11C1;
    localparam [12:0] HI_W12 = 13'h0441;
    localparam [12:0] HI_W13 = 13'h0501;
    localparam [12:0] HI_W14 = 13'h0781;
    localparam [12:0] HI_W15 = 13'h0741;

    reg [2:0] state;
    reg [5:0] cnt;
    reg [2:0] strap_sync;
    reg strap;
    reg [13:0] addr;
    wire in_range;
    wire [12:0] low_word;
    wire [12:0] high_word;
    reg [2:0] next_state;
    reg [5:0] next_cnt;
    reg [12:0] cell_lo [0:31];
    reg [12:0] cell_hi [0:31];
    wire [415:0] lo_cells;
    wire [415:0] hi_cells;
    wire [9:0] range_bits;
    wire load_now;
    reg [1:0] next_grp_drv;
    reg [7:0] next_line_drv;
    reg [25:0] next_mdr;
    genvar gi;

    // strap pin through three flops, accepted once the last two agree
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_sync <= 3'b000;
            strap <= 1'b0;
        end else begin
            strap_sync <= {strap_sync[1:0], alt_half};
            if (strap_sync[1] == strap_sync[2])
                strap <= strap_sync[2];
        end
    end

    assign range_bits = addr[13:4];
    assign in_range = (range_bits == `BSROM_RANGE_HI);
    assign load_now = (state == ST_READ) && (cnt == STROBE_CYC[5:0]);

    // prewired store in flops; spare copy holds the same sixteen words
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cell_lo[5'h00] <= LO_W0;
            cell_lo[5'h01] <= LO_W1;
            cell_lo[5'h02] <= LO_W2;
            cell_lo[5'h03] <= LO_W3;
            cell_lo[5'h04] <= LO_W4;
            cell_lo[5'h05] <= LO_W5;
            cell_lo[5'h06] <= LO_W6;
            cell_lo[5'h07] <= LO_W7;
            cell_lo[5'h08] <= LO_W8;
            cell_lo[5'h09] <= LO_W9;
            cell_lo[5'h0A] <= LO_W10;
            cell_lo[5'h0B] <= LO_W11;
            cell_lo[5'h0C] <= LO_W12;
            cell_lo[5'h0D] <= LO_W13;
            cell_lo[5'h0E] <= LO_W14;
            cell_lo[5'h0F] <= LO_W15;
            // spare copy, lower half
            cell_lo[5'h10] <= LO_W0;
            cell_lo[5'h11] <= LO_W1;
            cell_lo[5'h12] <= LO_W2;
            cell_lo[5'h13] <= LO_W3;
            cell_lo[5'h14] <= LO_W4;
            cell_lo[5'h15] <= LO_W5;
            cell_lo[5'h16] <= LO_W6;
            cell_lo[5'h17] <= LO_W7;
            cell_lo[5'h18] <= LO_W8;
            cell_lo[5'h19] <= LO_W9;
            cell_lo[5'h1A] <= LO_W10;
            cell_lo[5'h1B] <= LO_W11;
            cell_lo[5'h1C] <= LO_W12;
            cell_lo[5'h1D] <= LO_W13;
            cell_lo[5'h1E] <= LO_W14;
            cell_lo[5'h1F] <= LO_W15;
            cell_hi[5'h00] <= HI_W0;
            cell_hi[5'h01] <= HI_W1;
            cell_hi[5'h02] <= HI_W2;
            cell_hi[5'h03] <= HI_W3;
            cell_hi[5'h04] <= HI_W4;
            cell_hi[5'h05] <= HI_W5;
            cell_hi[5'h06] <= HI_W6;
            cell_hi[5'h07] <= HI_W7;
            cell_hi[5'h08] <= HI_W8;
            cell_hi[5'h09] <= HI_W9;
            cell_hi[5'h0A] <= HI_W10;
            cell_hi[5'h0B] <= HI_W11;
            cell_hi[5'h0C] <= HI_W12;
            cell_hi[5'h0D] <= HI_W13;
            cell_hi[5'h0E] <= HI_W14;
            cell_hi[5'h0F] <= HI_W15;
            // spare copy, upper half
            cell_hi[5'h10] <= HI_W0;
            cell_hi[5'h11] <= HI_W1;
            cell_hi[5'h12] <= HI_W2;
            cell_hi[5'h13] <= HI_W3;
            cell_hi[5'h14] <= HI_W4;
            cell_hi[5'h15] <= HI_W5;
            cell_hi[5'h16] <= HI_W6;
            cell_hi[5'h17] <= HI_W7;
            cell_hi[5'h18] <= HI_W8;
            cell_hi[5'h19] <= HI_W9;
            cell_hi[5'h1A] <= HI_W10;
            cell_hi[5'h1B] <= HI_W11;
            cell_hi[5'h1C] <= HI_W12;
            cell_hi[5'h1D] <= HI_W13;
            cell_hi[5'h1E] <= HI_W14;
            cell_hi[5'h1F] <= HI_W15;
        end
    end

    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_flat
            assign lo_cells[gi*13 +: 13] = cell_lo[gi];
            assign hi_cells[gi*13 +: 13] = cell_hi[gi];
        end
    endgenerate

    // strap picks the copy, so both halves read the same word index
    bsrom_half #(.WORDS(32), .HALF_W(`BSROM_HALF_W)) u_low (
        .alt_half(strap),
        .grp(addr[`BSROM_GRP_BIT]),
        .line(addr[2:0]),
        .cells(lo_cells),
        .word(low_word)
    );
    bsrom_half #(.WORDS(32), .HALF_W(`BSROM_HALF_W)) u_high (
        .alt_half(strap),
        .grp(addr[`BSROM_GRP_BIT]),
        .line(addr[2:0]),
        .cells(hi_cells),
        .word(high_word)
    );

    // drivers follow the address; all idle outside the range
    always @* begin
        next_grp_drv = 2'h0;
        next_line_drv = 8'h00;
        if (in_range) begin
            case (addr[`BSROM_GRP_BIT])
                1'h0: next_grp_drv = 2'h1;
                1'h1: next_grp_drv = 2'h2;
                default: next_grp_drv = 2'h0;
            endcase
            case (addr[2:0])
                3'h0: next_line_drv = 8'h01;
                3'h1: next_line_drv = 8'h02;
                3'h2: next_line_drv = 8'h04;
                3'h3: next_line_drv = 8'h08;
                3'h4: next_line_drv = 8'h10;
                3'h5: next_line_drv = 8'h20;
                3'h6: next_line_drv = 8'h40;
                3'h7: next_line_drv = 8'h80;
                default: next_line_drv = 8'h00;
            endcase
        end
    end

    // data register clears at start, then at the strobe takes the store word in range, else the core word
    always @* begin
        next_mdr = mdr;
        if (start && state == ST_IDLE)
            next_mdr = 26'h0000000;
        else if (load_now) begin
            if (in_range)
                next_mdr = {high_word, low_word};
            else
                next_mdr = core_word;
        end
    end

    always @* begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_READ;
                    next_cnt = 6'h01;
                end
            end
            ST_READ: begin
                next_cnt = cnt + 6'h01;
                if (cnt == STROBE_CYC[5:0])
                    next_state = ST_RESTORE;
            end
            ST_RESTORE: begin
                next_cnt = cnt + 6'h01;
                if (cnt == CYCLE_CYC[5:0]) begin
                    next_state = ST_IDLE;
                    next_cnt = 6'h00;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_cnt = 6'h00;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            cnt <= 6'h00;
            addr <= 14'h0000;
            grp_drv <= 2'h0;
            line_drv <= 8'h00;
            boot_en <= 1'b0;
            boot_gate <= 1'b0;
            mdr <= 26'h0000000;
            read_strobe <= 1'b0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            addr <= mar;
            busy <= (next_state != ST_IDLE);
            // drivers follow the address; all idle outside the range
            boot_en <= in_range;
            boot_gate <= in_range;
            grp_drv <= next_grp_drv;
            line_drv <= next_line_drv;
            read_strobe <= load_now;
            mdr <= next_mdr;
        end
    end
endmodule

// ==== verif/bsrom_asserts.sv ====
// checker for the bootstrap read path
`timescale 1ns/100ps
module bsrom_asserts (input clk, arst_n, start, boot_en, boot_gate, read_strobe, busy,
    input [13:0] mar, input [25:0] core_word, mdr, input [1:0] grp_drv, input [7:0] line_drv);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    reg [13:0] m1, m2;
    wire go = start && !busy;
    always @(posedge clk) begin
        m1 <= mar;
        m2 <= m1;
    end
    range_dec_a: assert property (boot_en == (m2[13:4] == 10'h003)) else $error("range");
    gate_pair_a: assert property (boot_gate == boot_en) else $error("gate");
    group_sel_a: assert property (boot_en |-> grp_drv == {m2[3], !m2[3]}) else $error("grp");
    line_sel_a: assert property (boot_en |-> line_drv == 8'h01 << m2[2:0]) else $error("line");
    idle_out_a: assert property (!boot_en |-> grp_drv == 2'h0 && line_drv == 8'h00) else $error("idle");
    load_time_a: assert property (go |=> mdr == 26'h0 ##10 read_strobe) else $error("load");
    strobe_one_a: assert property (read_strobe |=> !read_strobe) else $error("pulse");
    cycle_len_a: assert property (go |=> busy ##39 busy ##1 !busy) else $error("cycle");
    core_data_a: assert property (read_strobe && !boot_en |-> mdr == core_word) else $error("core");
    cover property (go && m2[13:4] == 10'h003);
    cover property (read_strobe && !boot_en);
    cover property (start && busy);
endmodule

// ==== verif/bsrom_core_model.sv ====
// core memory model feeding sense data
`timescale 1ns/100ps
module bsrom_core_model (input clk, boot_en, input [13:0] mar, output reg [25:0] core_word);
    initial core_word = 26'h0;
    // inhibited core reads nothing: lines scramble
    always @(posedge clk)
        core_word <= boot_en ? ~core_word : {mar, mar[11:0]} ^ 26'h2A5A5A5;
endmodule

// ==== verif/bootstrap_rom_read_path_tb_top.sv ====
// bench for the bootstrap read path
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module bootstrap_rom_read_path_tb_top;
    reg clk = 0, arst_n = 0, start = 0, alt_half = 0;
    reg [13:0] mar = 14'h0;
    reg [31:0] seed = 32'hC1EA;
    reg [25:0] rom [0:15];
    wire [25:0] core_word, mdr;
    wire [1:0] grp_drv;
    wire [7:0] line_drv;
    wire boot_en, boot_gate, read_strobe, busy;
    integer failures = 0, checks_done = 0, i, n;
    bsrom_path #(.STROBE_CYC(10), .CYCLE_CYC(40)) dut (.clk(clk), .arst_n(arst_n), .mar(mar),
        .start(start), .alt_half(alt_half), .core_word(core_word), .grp_drv(grp_drv),
        .line_drv(line_drv), .boot_en(boot_en), .boot_gate(boot_gate), .mdr(mdr),
        .read_strobe(read_strobe), .busy(busy));
    bsrom_core_model core (.clk(clk), .boot_en(boot_en), .mar(mar), .core_word(core_word));
    initial forever #50 clk = ~clk;
    function [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction
    task test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task access(input [13:0] a, input alt);
        reg hit;
        hit = a[13:4] == 10'h003;
        @(negedge clk) mar = a;
        alt_half = alt;
        repeat (3) @(negedge clk);
        `CHK(boot_en, hit)
        `CHK(boot_gate, hit)
        `CHK(grp_drv, hit ? (a[3] ? 2'h2 : 2'h1) : 2'h0)
        `CHK(line_drv, hit ? 8'h01 << a[2:0] : 8'h00)
        start = 1;
        for (n = 0; n == 0 || (!read_strobe && n < 20); n++) @(negedge clk) start = 0;
        `CHK(n, 11)
        if (!hit) `CHK(mdr, core_word)
        else if (alt) `CHK(mdr, rom[a[3:0]])
        else rom[a[3:0]] = mdr;
        if (hit) `CHK(mdr[12], ~^mdr[11:0])
        if (hit) `CHK(mdr[25], ~^mdr[24:13])
        for (n = 0; busy && n < 60; n++) @(negedge clk) start = (n == 4);
        `CHK(n, 30)
        if (n == 60) test_done;
        $display("access %h done", a);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        arst_n = 1;
        for (i = 0; i < 32; i++) access(14'h30 + i[3:0], i[4]);
        access(14'h2F, 0);
        access(14'h40, 1);
        for (i = 0; i < 24; i++) begin
            seed = xs(seed);
            access(seed[15] ? seed[13:0] : {10'h003, seed[3:0]}, 1);
        end
        test_done;
    end
endmodule
bind bsrom_path bsrom_asserts chk (.clk(clk), .arst_n(arst_n), .start(start), .boot_en(boot_en),
    .boot_gate(boot_gate), .read_strobe(read_strobe), .busy(busy), .mar(mar),
    .core_word(core_word), .mdr(mdr), .grp_drv(grp_drv), .line_drv(line_drv));
